/* rtl/hbpic_pkg.sv */
// Package for the half-bridge PWM input control block.
// Assumes a single 250 MHz clock and an APB register port.
package hbpic_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] REP1_OFS = 8'h04;
  localparam logic [7:0] REP3_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam int CNT_SEL_BIT = 0;
  localparam int DET_EN_BIT = 1;
  localparam int AGC_LSB = 2;
  localparam int PCH_DIS_BIT = 4;
  localparam int SEL_LSB = 8;
  localparam int PEN_LSB = 16;
  localparam int DCHG_LSB = 24;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h3f07_3f1f;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [1:0] SEL_PASSIVE = 2'h0;
  localparam logic [1:0] SEL_LS_PWM = 2'h1;
  localparam logic [1:0] SEL_HS_PWM = 2'h2;
  localparam logic [1:0] SEL_HOLD = 2'h3;
  localparam logic [5:0] HARDOFF_CODE = 6'h3f;
  // ----------------------------------------
  // Timing, ns and cycles at 250 MHz
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int CCP_ACT_NS = 1000;
  localparam int CCP_FW_NS = 1000;
  localparam int BLANK_NS = 800;
  localparam int TOFF_FW_NS = 4000;
  localparam int CCP_ACT_CYC = (CCP_ACT_NS * CLK_MHZ + 999) / 1000;
  localparam int CCP_FW_CYC = (CCP_FW_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int TOFF_FW_CYC = (TOFF_FW_NS * CLK_MHZ) / 1000;
  localparam int TW = 12;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic hold_off;
    logic max_sink;
  } hbpic_gate_t;
  typedef struct packed {
    logic [7:0] tdon;
    logic [7:0] tdoff;
    logic [7:0] rise;
    logic [7:0] fall;
  } hbpic_rep_t;
  typedef enum logic [2:0] {M_IDLE, M_DON, M_RISE, M_DOFF, M_FALL} hbpic_meas_t;
endpackage

/* rtl/hbpic_top.sv */
// Half-bridge PWM input control: six PWM inputs to three gate command pairs.
// Assumes PWM inputs asynchronous to clk, analog switching-edge flags from the
// gate drivers, and an APB master with 32-bit data.
//
// Behaviour
// R1: Short on- or off-time makes the selected PWM MOSFET the active one.
// R2: In that short case the opposite MOSFET stays off.
// R3: Report PWM MOSFET times without detection, detected active MOSFET with it.
// R4: Rise end not seen within blanking time reports rise as zero.
// R5: Fall end not seen within active guard time reports fall as zero.
// R6: At extreme duty cycles all four reported times are zero.
// R7: Count select 1 and enable 1 drive each FET from its own input.
// R8: Select 00 keeps both FETs off by passive discharge, the default.
// R9: Select 11 keeps both FETs actively held off.
// R10: Select 01 without detection makes the low side active.
// R11: Select 10 without detection makes the high side active.
// R12: With detection, active and free-wheeling FETs come from the detector.
// R13: Inputs 1/2, 3/4, 5/6 drive bridges 1, 2, 3.
// R14: Select 01: low/high turns high side on, high/low low side, equal off.
// R15: Select 10: low/high turns low side on, high/low high side, equal off.
// R16: High-side edge after FW guard, before FW timeout: hard sink low side.
// R17: High-side activation blocked until the free-wheeling guard elapses.
// R18: Low-side activation blocked until the active guard elapses.
// R19: Adaptive control with post-charge: free-wheeling FET off before active on.
// R20: Adaptive control with post-charge: active FET off before free-wheeling on.
// R21: Hard-off sink uses discharge code 63.
// R22: Inputs pass a two-flop synchroniser; windows timed by clk counters.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module hbpic_top
  import hbpic_pkg::*;
#(
  parameter int NB = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM inputs, bit 0 is pwm_in_1
  input wire logic [2*NB-1:0] pwm_in,
  // Gate driver side
  input wire logic [NB-1:0] det_active_hs,
  input wire logic [NB-1:0] sw_start,
  input wire logic [NB-1:0] sw_end,
  output hbpic_gate_t [NB-1:0] gate_cmd,
  output logic [NB-1:0][5:0] discharge_current_code
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] ctrl_r;
  hbpic_rep_t [NB-1:0] rep_r;
  logic [NB-1:0] short_r;
  logic [NB-1:0] act_hs_r;
  hbpic_gate_t [NB-1:0] gate_r;
  logic wr_en;
  logic [31:0] rd_nxt;
  logic bad_addr;

  // Zero wait states: the access phase completes at its first edge
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign gate_cmd = gate_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_en && paddr == CTRL_OFS) begin
      ctrl_r <= pwdata & CTRL_MASK;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    bad_addr = 1'b0;
    if (paddr == CTRL_OFS) begin
      rd_nxt = ctrl_r;
    end else if (paddr == STAT_OFS) begin
      rd_nxt = {26'h0, act_hs_r, short_r};
    end else if (paddr >= REP1_OFS && paddr <= REP3_OFS && paddr[1:0] == 2'h0) begin
      rd_nxt = rep_r[paddr[3:2] - 2'h1];
    end else begin
      bad_addr = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : prdata;
      pslverr <= psel && !penable && bad_addr;
    end
  end

  // ----------------------------------------
  // Shared configuration
  // ----------------------------------------
  logic cnt_sel;
  logic det_en;
  logic adaptive;
  assign cnt_sel = ctrl_r[CNT_SEL_BIT];
  assign det_en = ctrl_r[DET_EN_BIT];
  assign adaptive = (ctrl_r[AGC_LSB+:2] == 2'h1 || ctrl_r[AGC_LSB+:2] == 2'h2) && !ctrl_r[PCH_DIS_BIT];

  // Two-input decode: returns {want_hs, want_ls}
  function automatic logic [1:0] decode(input logic [1:0] sel, input logic a, input logic b);
    logic [1:0] r;
    r = 2'h0;
    if (a != b) begin
      if (sel == SEL_LS_PWM) begin
        r = a ? 2'h1 : 2'h2; // R14
      end else if (sel == SEL_HS_PWM) begin
        r = a ? 2'h2 : 2'h1; // R15
      end
    end
    return r;
  endfunction

  // Saturating increment
  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  logic [2*NB-1:0] pwm_m_r;
  logic [2*NB-1:0] pwm_s_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_m_r <= '0;
      pwm_s_r <= '0;
    end else begin
      pwm_m_r <= pwm_in; // R22
      pwm_s_r <= pwm_m_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_sync_depth: assert property (!$past(srst) && !$past(srst, 2) |-> pwm_s_r == $past(pwm_in, 2)) // R22
    else $error("sync depth wrong");

  // ----------------------------------------
  // Per bridge
  // ----------------------------------------
  for (genvar i = 0; i < NB; i++) begin : g_hb
    logic [1:0] sel;
    logic pen;
    logic [1:0] want;
    logic pwm_is_hs;
    logic pf;
    logic pf_r;
    logic [TW-1:0] len_r;
    logic eff_hs;
    logic want_hs;
    logic want_ls;
    logic [TW-1:0] dead_r;
    logic last_ls_r;
    logic hs_nxt;
    logic ls_nxt;
    logic mf;
    logic mf_r;
    hbpic_meas_t ms_r;
    logic [TW-1:0] mc_r;
    logic [7:0] mc8;

    assign sel = ctrl_r[SEL_LSB+2*i+:2];
    assign pen = ctrl_r[PEN_LSB+i] && cnt_sel; // R7
    assign want = pen ? decode(sel, pwm_s_r[2*i], pwm_s_r[2*i+1]) : 2'h0; // R13
    assign pwm_is_hs = sel == SEL_HS_PWM;
    assign pf = pwm_is_hs ? want[1] : want[0];
    // Short-pulse: PWM FET forced active, opposite off
    assign eff_hs = short_r[i] ? pwm_is_hs : det_en ? det_active_hs[i] : pwm_is_hs; // R1 R10 R11 R12
    assign want_hs = want[1] && !(short_r[i] && !pwm_is_hs); // R2
    assign want_ls = want[0] && !(short_r[i] && pwm_is_hs); // R2

    // Pulse width of the PWM FET request decides short mode
    always_ff @(posedge clk) begin
      if (srst) begin
        pf_r <= 1'b0;
        len_r <= '0;
        short_r[i] <= 1'b0;
      end else begin
        pf_r <= pf;
        if (pf != pf_r) begin
          len_r <= '0;
          short_r[i] <= pf_r ? (len_r < TW'(CCP_FW_CYC)) : (len_r < TW'(CCP_ACT_CYC)); // R1
        end else begin
          len_r <= sat_inc(len_r);
        end
      end
    end

    // Break-before-make: opposite FET must be off and its guard elapsed
    assign hs_nxt = want_hs && !gate_r[i].ls_on && (gate_r[i].hs_on ||
      dead_r >= (eff_hs ? TW'(CCP_FW_CYC) : TW'(CCP_ACT_CYC))); // R17 R19
    assign ls_nxt = want_ls && !gate_r[i].hs_on && (gate_r[i].ls_on ||
      dead_r >= (eff_hs ? TW'(CCP_ACT_CYC) : TW'(CCP_FW_CYC))); // R18 R20

    always_ff @(posedge clk) begin
      if (srst) begin
        dead_r <= '0;
        last_ls_r <= 1'b0;
      end else if ((gate_r[i].hs_on && !hs_nxt) || (gate_r[i].ls_on && !ls_nxt)) begin
        dead_r <= '0;
        last_ls_r <= gate_r[i].ls_on;
      end else begin
        dead_r <= sat_inc(dead_r);
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        gate_r[i] <= '0;
        act_hs_r[i] <= 1'b0;
      end else begin
        gate_r[i].hs_on <= hs_nxt;
        gate_r[i].ls_on <= ls_nxt;
        gate_r[i].hold_off <= sel == SEL_HOLD; // R8 R9
        // Late edge within the FW window: low side hard-sunk
        gate_r[i].max_sink <= adaptive && hs_nxt && last_ls_r && dead_r < TW'(TOFF_FW_CYC); // R16
        act_hs_r[i] <= eff_hs;
      end
    end

    assign discharge_current_code[i] = gate_r[i].max_sink ? HARDOFF_CODE : ctrl_r[DCHG_LSB+:6]; // R21

    // ----------------------------------------
    // Switching-time measurement
    // ----------------------------------------
    assign mf = (det_en ? eff_hs : pwm_is_hs) ? gate_r[i].hs_on : gate_r[i].ls_on; // R3
    assign mc8 = (mc_r > TW'(255)) ? 8'hff : mc_r[7:0];

    always_ff @(posedge clk) begin
      if (srst) begin
        mf_r <= 1'b0;
        ms_r <= M_IDLE;
        mc_r <= '0;
        rep_r[i] <= '0;
      end else begin
        mf_r <= mf;
        mc_r <= sat_inc(mc_r);
        if (short_r[i]) begin
          rep_r[i] <= '0; // R6
          ms_r <= M_IDLE;
        end else if (mf && !mf_r) begin
          ms_r <= M_DON;
          mc_r <= '0;
        end else if (!mf && mf_r) begin
          ms_r <= M_DOFF;
          mc_r <= '0;
        end else begin
          unique case (ms_r)
            M_IDLE: begin
            end
            M_DON, M_DOFF: begin
              if (sw_start[i]) begin
                if (ms_r == M_DON) begin
                  rep_r[i].tdon <= mc8;
                end else begin
                  rep_r[i].tdoff <= mc8;
                end
                ms_r <= (ms_r == M_DON) ? M_RISE : M_FALL;
                mc_r <= '0;
              end
            end
            M_RISE: begin
              if (mc_r >= TW'(BLANK_CYC)) begin
                rep_r[i].rise <= 8'h00; // R4
                ms_r <= M_IDLE;
              end else if (sw_end[i]) begin
                rep_r[i].rise <= mc8;
                ms_r <= M_IDLE;
              end
            end
            M_FALL: begin
              if (mc_r >= TW'(CCP_ACT_CYC)) begin
                rep_r[i].fall <= 8'h00; // R5
                ms_r <= M_IDLE;
              end else if (sw_end[i]) begin
                rep_r[i].fall <= mc8;
                ms_r <= M_IDLE;
              end
            end
          endcase
        end
      end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_passive;
      (sel == SEL_PASSIVE) [*2];
    endsequence
    sequence s_ls_rise;
      !gate_r[i].ls_on ##1 gate_r[i].ls_on;
    endsequence
    sequence s_hs_rise;
      !gate_r[i].hs_on ##1 gate_r[i].hs_on;
    endsequence

    a_sel_passive: assert property (s_passive |=> !gate_r[i].hs_on && !gate_r[i].ls_on && !gate_r[i].hold_off)
      else $error("passive select not off"); // R8
    a_sel_hold: assert property ((sel == SEL_HOLD) |=> gate_r[i].hold_off && !gate_r[i].hs_on && !gate_r[i].ls_on)
      else $error("hold select not held off"); // R9
    a_no_overlap: assert property (!(gate_r[i].hs_on && gate_r[i].ls_on))
      else $error("both FETs on"); // R19
    a_ls_guard: assert property (s_ls_rise |-> $past(dead_r) >= TW'(CCP_ACT_CYC) || $past(dead_r) >= TW'(CCP_FW_CYC))
      else $error("low side on inside guard"); // R18
    a_hs_guard: assert property (s_hs_rise |-> !$past(gate_r[i].ls_on, 2) && $past(dead_r) >= TW'(CCP_ACT_CYC))
      else $error("high side on inside guard"); // R17
    a_short_opp: assert property (short_r[i] && pwm_is_hs |=> !gate_r[i].ls_on)
      else $error("opposite FET on in short mode"); // R2
    a_short_rep: assert property (short_r[i] |=> rep_r[i] == '0)
      else $error("report not zero at extreme duty"); // R6
    a_rise_blank: assert property (ms_r == M_RISE && mc_r >= TW'(BLANK_CYC) && !short_r[i] && mf == mf_r
      |=> rep_r[i].rise == 8'h00 && ms_r == M_IDLE) else $error("late rise not zero"); // R4
    a_hardoff_code: assert property (gate_r[i].max_sink |-> discharge_current_code[i] == 6'h3f)
      else $error("hard-off code wrong"); // R21
  end
endmodule
`default_nettype wire

/* verification/hbpic_pwm_src.sv */
// Far-side model: controller timer on the PWM pins and gate driver edge flags.
// Assumes the block's clock; the bench sets the pin levels and the flag switch.
`timescale 1ns/10ps
`default_nettype none
module hbpic_pwm_src
  import hbpic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bench side
  input wire logic [5:0] lvl,
  input wire logic fb_en,
  // Block side
  output logic [5:0] pwm_in,
  input wire hbpic_gate_t [2:0] gate_cmd,
  output logic [2:0] sw_start,
  output logic [2:0] sw_end
);
  logic [2:0][1:0] last_r;
  logic [2:0][5:0] cnt_r;

  // Two pins per bridge, first input in the even bit
  always_ff @(posedge clk) begin
    pwm_in <= lvl;
  end

  // ----------------------------------------
  // Switching feedback
  // ----------------------------------------
  // Flags follow each gate change; with fb_en low the end never comes
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      last_r[i] <= {gate_cmd[i].hs_on, gate_cmd[i].ls_on};
      if (srst) begin
        cnt_r[i] <= 6'h0;
      end else if (last_r[i] != {gate_cmd[i].hs_on, gate_cmd[i].ls_on}) begin
        cnt_r[i] <= 6'h1;
      end else if (cnt_r[i] != 6'h0 && cnt_r[i] != 6'h3f) begin
        cnt_r[i] <= cnt_r[i] + 6'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sw_start[i] = cnt_r[i] == 6'ha;
      sw_end[i] = fb_en && cnt_r[i] == 6'h14;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Bench for the half-bridge PWM input control block.
// Assumes the block and the PWM source model are compiled beside it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top
  import hbpic_pkg::*;
;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, fb_en, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [5:0] lvl, lv, pwm_in;
  logic [2:0] det_hs, sw_start, sw_end, seen, ls_seen;
  hbpic_gate_t [2:0] gate_cmd;
  logic [2:0][5:0] dcode;
  int checks = 0;
  int bad_count = 0;
  int cyc = 0;

  hbpic_top #(.NB(3)) DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_in(pwm_in), .det_active_hs(det_hs), .sw_start(sw_start), .sw_end(sw_end),
    .gate_cmd(gate_cmd), .discharge_current_code(dcode));
  hbpic_pwm_src SRC (.clk(clk), .srst(srst), .lvl(lvl), .fb_en(fb_en), .pwm_in(pwm_in),
    .gate_cmd(gate_cmd), .sw_start(sw_start), .sw_end(sw_end));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      test_done;
    end
  end

  // ----------------------------------------
  // Bus and watch tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a stalled access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    `CHK("pready", 1'b1, pready)
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Every cycle: no shoot-through, sink code follows the hard-off flag
  task automatic watch(input int n);
    repeat (n) begin
      @(posedge clk);
      for (int b = 0; b < 3; b++) begin
        `CHK("overlap", 1'b0, gate_cmd[b].hs_on & gate_cmd[b].ls_on)
        `CHK("dchg", gate_cmd[b].max_sink ? HARDOFF_CODE : 6'h15, dcode[b])
        seen[b] = seen[b] | gate_cmd[b].max_sink;
        ls_seen[b] = ls_seen[b] | gate_cmd[b].ls_on;
      end
    end
  endtask

  function automatic logic [3:0] eg(input int s, input logic [1:0] v);
    if (s == 3) return 4'h2;
    if (s == 0 || v[0] == v[1]) return 4'h0;
    return ((s == 1) == (v == 2'b10)) ? 4'h8 : 4'h4;
  endfunction

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lvl = 6'h0;
    fb_en = 1'b0;
    det_hs = 3'h0;
    seen = 3'h0;
    ls_seen = 3'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl", CTRL_RST, rq)
    `CHK("gates", 12'h0, gate_cmd)
    apb(1'b1, 8'h40, 32'hffff_ffff);
    `CHK("err", 1'b1, re)
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h0, rq)
    $display("test reset done");
    // Each bridge walks all level pairs, offset so bridges differ
    for (int s = 0; s < 4; s++) begin
      // Park the pins first: old levels under a new select make a short pulse
      lvl <= 6'h0;
      if (s != 0) watch(300);
      apb(1'b1, CTRL_OFS, 32'h1507_0001 | (s * 32'h1500));
      for (int k = 0; k < 4; k++) begin
        for (int b = 0; b < 3; b++) lv[2*b +: 2] = 2'(k + b);
        lvl <= lv;
        watch(300);
        for (int b = 0; b < 3; b++) `CHK("gate", eg(s, 2'(k + b)), gate_cmd[b])
      end
    end
    $display("test tables done");
    apb(1'b1, CTRL_OFS, 32'h1500_1501);
    lvl <= 6'h2a;
    watch(300);
    `CHK("gates", 12'h0, gate_cmd)
    apb(1'b1, CTRL_OFS, 32'h1507_1501);
    watch(300);
    `CHK("gates", 12'h888, gate_cmd)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK("act", 3'h0, rq[5:3])
    for (int j = 0; j < 2; j++) begin
      lvl <= j ? 6'h2a : 6'h15;
      watch(100);
      `CHK("gates", 12'h0, gate_cmd)
      watch(200);
      `CHK("gates", j ? 12'h888 : 12'h444, gate_cmd)
    end
    $display("test guard done");
    apb(1'b1, CTRL_OFS, 32'h1507_2a05);
    watch(300);
    seen = 3'h0;
    lvl <= 6'h15;
    watch(400);
    `CHK("sink", 3'h7, seen)
    `CHK("gates", 12'h888, gate_cmd & 12'heee)
    lvl <= 6'h2a;
    watch(400);
    `CHK("gates", 12'h444, gate_cmd & 12'heee)
    $display("test adaptive done");
    apb(1'b1, CTRL_OFS, 32'h1507_2a01);
    lvl <= 6'h0;
    watch(300);
    ls_seen = 3'h0;
    lvl <= 6'h01;
    watch(50);
    lvl <= 6'h02;
    watch(300);
    `CHK("fw", 1'b0, ls_seen[0])
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK("short", 2'b11, {rq[3], rq[0]})
    apb(1'b0, REP1_OFS, 32'h0);
    `CHK("rep", 32'h0, rq)
    for (int f = 0; f < 2; f++) begin
      fb_en <= f[0];
      lvl <= 6'h01;
      watch(600);
      lvl <= 6'h0;
      watch(600);
      apb(1'b0, REP1_OFS, 32'h0);
      `CHK("rise", f != 0, rq[15:8] != 8'h0)
      `CHK("fall", f != 0, rq[7:0] != 8'h0)
    end
    $display("test measure done");
    apb(1'b1, CTRL_OFS, 32'h1507_1503);
    det_hs <= 3'h7;
    watch(10);
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK("act", 3'h7, rq[5:3])
    $display("test detect done");
    test_done;
  end
endmodule
`default_nettype wire
